// *** common/asp_params.svh ***
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

`define ASP_CMD_BITS 8
`define ASP_CMD_LAST 3'h7
`define ASP_WORD_BITS 16
`define ASP_WORD_LAST 4'hF
`define ASP_RES_BITS 12
`define ASP_PAD_BITS 4
`define ASP_FIFO_DEPTH 4
`define ASP_CONV_BIT 7
`define ASP_SETUP_HI 7
`define ASP_SETUP_LO 6
`define ASP_SETUP_CODE 2'h1
`define ASP_CK_HI 5
`define ASP_CK_LO 4
`define ASP_REF_HI 3
`define ASP_REF_LO 2
`define ASP_REF_EXT_NEG 2'h2
`define ASP_REFSEL_RST 2'h0

`endif

// *** common/asp_pkg.sv ***
`default_nettype none
package asp_pkg;

	typedef enum logic [1:0] {
		ASP_CK_CNV_SCAN = 2'b00,
		ASP_CK_CNV_SINGLE = 2'b01,
		ASP_CK_SERIAL = 2'b10,
		ASP_CK_EXT = 2'b11
	} asp_ckmode_t;

	localparam asp_ckmode_t ASP_CK_RST = ASP_CK_SERIAL;

endpackage
`default_nettype wire

// *** rtl/asp_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module asp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [CW-1:0] count;
		logic full;
		logic nonempty;
	} asp_fifo_st_t;

	asp_fifo_st_t q, d;
	logic push, pop;

	always_comb begin
		d = q;
		push = in_valid && !q.full;
		pop = out_ready && q.nonempty;
		if (push) begin
			d.mem[q.wr_ptr] = in_data;
			d.wr_ptr = (q.wr_ptr == LAST_PTR) ? '0 : q.wr_ptr + 1'b1;
		end
		if (pop) begin
			d.rd_ptr = (q.rd_ptr == LAST_PTR) ? '0 : q.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			d.count = q.count + 1'b1;
		end else if (pop && !push) begin
			d.count = q.count - 1'b1;
		end
		// Flags are registered so that the ready seen upstream comes from a flop.
		d.full = (d.count == FULL_CNT);
		d.nonempty = (d.count != '0);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign in_ready = !q.full;
	assign out_valid = q.nonempty;
	assign out_data = q.mem[q.rd_ptr];

endmodule // asp_fifo
`default_nettype wire

// *** rtl/asp_serial_port.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "asp_params.svh"
module asp_serial_port
	import asp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic conversion_start_n,
	output logic dout,
	output logic dout_oe,
	output logic eoc_n,
	output logic conv_req,
	output logic conversion_start_n_is_start,
	output logic ref_neg_is_ref,
	input wire logic result_valid,
	output logic result_ready,
	input wire logic [`ASP_RES_BITS-1:0] result_data
);
	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_prev;
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_prev;
		logic din_s1;
		logic din_s2;
		logic cnv_s1;
		logic cnv_s2;
		logic cnv_prev;
		logic [2:0] bit_cnt;
		logic first_byte;
		logic [`ASP_CMD_BITS-1:0] rx_sr;
		asp_ckmode_t cksel;
		logic [1:0] refsel;
		logic [`ASP_WORD_BITS-1:0] tx_sr;
		logic [3:0] tx_cnt;
		logic tx_held;
		logic dout;
		logic dout_oe;
		logic eoc_n;
		logic conv_req;
		logic cnv_is_start;
		logic ref_is_ref;
	} asp_st_t;

	asp_st_t q, d;
	logic fifo_valid;
	logic fifo_pop;
	logic push;
	logic cs_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic cnv_fall;
	logic start_mode;
	logic [`ASP_CMD_BITS-1:0] byte_w;
	logic [`ASP_WORD_BITS-1:0] fifo_data;

	// Results are packed right-justified into a full serial word.
	asp_fifo #(
		.WIDTH(`ASP_WORD_BITS),
		.DEPTH(`ASP_FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_valid(result_valid),
		.in_ready(result_ready),
		.in_data({{`ASP_PAD_BITS{1'b0}}, result_data}),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	assign push = result_valid && result_ready;

	always_comb begin
		d = q;
		d.cs_s1 = cs_n;
		d.cs_s2 = q.cs_s1;
		d.cs_prev = q.cs_s2;
		d.sclk_s1 = sclk;
		d.sclk_s2 = q.sclk_s1;
		d.sclk_prev = q.sclk_s2;
		d.din_s1 = din;
		d.din_s2 = q.din_s1;
		d.cnv_s1 = conversion_start_n;
		d.cnv_s2 = q.cnv_s1;
		d.cnv_prev = q.cnv_s2;
		d.conv_req = 1'b0;
		fifo_pop = 1'b0;
		cs_fall = q.cs_prev && !q.cs_s2;
		// Edges count only while selected, so a parked clock of either level is harmless.
		// edges only when selected
		sclk_rise = !q.cs_s2 && !cs_fall && !q.sclk_prev && q.sclk_s2;
		sclk_fall = !q.cs_s2 && !cs_fall && q.sclk_prev && !q.sclk_s2;
		start_mode = (q.cksel == ASP_CK_CNV_SCAN) || (q.cksel == ASP_CK_CNV_SINGLE);
		cnv_fall = start_mode && q.cnv_prev && !q.cnv_s2;
		byte_w = {q.rx_sr[`ASP_CMD_BITS-2:0], q.din_s2};
		if (cs_fall) begin
			d.bit_cnt = '0;
			d.first_byte = 1'b1;
			d.tx_cnt = '0;
			// A word taken at the end of the last frame was never shifted, so it is still owed.
			if (!q.tx_held) begin
				d.tx_sr = fifo_valid ? fifo_data : '0;
				fifo_pop = fifo_valid;
			end
			d.tx_held = 1'b0;
		end
		if (sclk_rise) begin
			d.rx_sr = byte_w;
			d.bit_cnt = q.bit_cnt + 3'h1;
			if (q.bit_cnt == `ASP_CMD_LAST && q.first_byte) begin
				d.first_byte = 1'b0;
				if (byte_w[`ASP_CONV_BIT]) begin
					d.conv_req = (q.cksel == ASP_CK_SERIAL) || (q.cksel == ASP_CK_EXT);
				end else if (byte_w[`ASP_SETUP_HI:`ASP_SETUP_LO] == `ASP_SETUP_CODE) begin
					d.cksel = asp_ckmode_t'(byte_w[`ASP_CK_HI:`ASP_CK_LO]);
					d.refsel = byte_w[`ASP_REF_HI:`ASP_REF_LO];
				end
			end
		end
		if (sclk_fall) begin
			if (q.tx_cnt == `ASP_WORD_LAST) begin
				d.tx_cnt = '0;
				d.tx_sr = fifo_valid ? fifo_data : '0;
				d.tx_held = fifo_valid;
				fifo_pop = fifo_valid;
			end else begin
				d.tx_cnt = q.tx_cnt + 4'h1;
				d.tx_sr = {q.tx_sr[`ASP_WORD_BITS-2:0], 1'b0};
				d.tx_held = 1'b0;
			end
		end
		d.dout = d.tx_sr[`ASP_WORD_BITS-1];
		d.dout_oe = !q.cs_s2;
		// A start pulse also launches an internally timed conversion.
		if (cnv_fall) begin
			d.conv_req = 1'b1;
		end
		if (q.cksel == ASP_CK_EXT) begin
			d.eoc_n = 1'b1;
		end else if (push) begin
			d.eoc_n = 1'b0;
		end else if (cs_fall || cnv_fall) begin
			d.eoc_n = 1'b1;
		end
		d.cnv_is_start = start_mode;
		d.ref_is_ref = (q.refsel == `ASP_REF_EXT_NEG);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			q <= '0;
			q.cs_s1 <= 1'b1;
			q.cs_s2 <= 1'b1;
			q.cs_prev <= 1'b1;
			q.cnv_s1 <= 1'b1;
			q.cnv_s2 <= 1'b1;
			q.cnv_prev <= 1'b1;
			q.first_byte <= 1'b1;
			q.cksel <= ASP_CK_RST;
			q.refsel <= `ASP_REFSEL_RST;
			q.eoc_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign dout = q.dout;
	assign dout_oe = q.dout_oe;
	assign eoc_n = q.eoc_n;
	assign conv_req = q.conv_req;
	assign conversion_start_n_is_start = q.cnv_is_start;
	assign ref_neg_is_ref = q.ref_is_ref;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_idle_ignore: assert property (q.cs_s2 |=> $stable(q.rx_sr) && $stable(q.bit_cnt))
		else $error("Receive state moved while deselected.");
	a_dout_release: assert property ($rose(q.cs_s2) |=> !dout_oe)
		else $error("Data output still driven after deselect.");
	a_rx_capture: assert property (sclk_rise |=> q.rx_sr[0] == $past(q.din_s2))
		else $error("Input bit not captured on rising clock.");
	a_tx_hold: assert property (!sclk_fall && !cs_fall |=> $stable(q.tx_sr))
		else $error("Output word changed without a falling clock.");
	a_eoc_low: assert property (push && q.cksel != ASP_CK_EXT |=> !eoc_n)
		else $error("Done output not low after a new result.");
	a_start_role: assert property (##1 conversion_start_n_is_start == ($past(q.cksel) inside {ASP_CK_CNV_SCAN,
		ASP_CK_CNV_SINGLE}))
		else $error("Start pin role disagrees with clock mode.");
	a_ref_role: assert property (##1 ref_neg_is_ref == ($past(q.refsel) == `ASP_REF_EXT_NEG))
		else $error("Reference pin role disagrees with setup.");
	a_setup_byte: assert property (sclk_rise && q.bit_cnt == `ASP_CMD_LAST && q.first_byte
		&& byte_w[`ASP_SETUP_HI:`ASP_CONV_BIT - 1] == `ASP_SETUP_CODE
		|=> q.cksel == asp_ckmode_t'($past(byte_w[`ASP_CK_HI:`ASP_CK_LO])))
		else $error("Setup byte did not set the clock mode.");
	a_eoc_raise: assert property ((cs_fall || cnv_fall) && !push |=> eoc_n)
		else $error("Done output not raised by select or start.");
	a_eoc_ext: assert property (q.cksel == ASP_CK_EXT |=> eoc_n ##1 eoc_n || q.cksel != ASP_CK_EXT)
		else $error("Done output low in external clock mode.");
	a_cnt_clear: assert property (cs_fall |=> q.bit_cnt == 3'h0 && q.first_byte)
		else $error("Bit counter not cleared by select.");

	c_setup_write: cover property (sclk_rise && q.first_byte && q.bit_cnt == `ASP_CMD_LAST);
	c_conv_cmd: cover property (conv_req);
	c_word_pop: cover property (fifo_pop && sclk_fall);
	c_start_pin: cover property (cnv_fall);
	c_held_word: cover property (cs_fall && q.tx_held);

endmodule // asp_serial_port
`default_nettype wire

// *** sim/asp_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module asp_master_model (
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout_pin
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	task automatic xfer(input logic sel, input logic [7:0] cmd, input int nbits,
		output logic [15:0] rx);
		rx = 16'h0000;
		cs_n = ~sel;
		for (int i = 0; i < nbits; i++) begin
			din = (i < 8) ? cmd[7 - i] : 1'b0;
			// Even halves, din set a half period early.
			#200 sclk = 1'b1;
			rx = {rx[14:0], dout_pin};
			#200 sclk = 1'b0;
		end
		#200 cs_n = 1'b1;
		din = ~din;
	endtask
endmodule // asp_master_model
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic conversion_start_n = 1'b1;
	logic result_valid = 1'b0;
	logic [11:0] result_data = 12'h000;
	logic cs_n, sclk, din, dout, dout_oe, eoc_n, conv_req, conversion_start_n_is_start, ref_neg_is_ref;
	logic result_ready;
	logic [15:0] rx;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_conv = 0;
	int n_oe = 0;
	wire dout_pin = dout_oe ? dout : 1'bz;
	always #25 core_clk = ~core_clk;
	asp_serial_port DUT (.core_clk(core_clk), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk),
		.din(din), .conversion_start_n(conversion_start_n), .dout(dout), .dout_oe(dout_oe),
		.eoc_n(eoc_n), .conv_req(conv_req), .conversion_start_n_is_start(conversion_start_n_is_start),
		.ref_neg_is_ref(ref_neg_is_ref), .result_valid(result_valid),
		.result_ready(result_ready), .result_data(result_data));
	asp_master_model M (.cs_n(cs_n), .sclk(sclk), .din(din), .dout_pin(dout_pin));
	always @(posedge core_clk) begin
		n_conv <= n_conv + int'(conv_req === 1'b1);
		n_oe <= n_oe + int'(dout_oe === 1'b1);
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic push(input logic [11:0] d);
		result_valid = 1'b1;
		result_data = d;
		cyc(1);
		// A gap cycle keeps back-to-back calls from toggling the strobe twice in one step.
		result_valid = 1'b0;
		cyc(1);
	endtask
	task automatic frame(input logic [7:0] cmd, input int nb);
		M.xfer(1'b1, cmd, nb, rx);
		cyc(6);
	endtask
	task automatic t_read();
		int c;
		push(12'hA5C);
		push(12'h3F1);
		cyc(1);
		chk(eoc_n, 1'b0, "eoc low");
		c = n_conv;
		frame(8'h80, 16);
		chk(rx, 16'h0A5C, "word 1");
		chk(16'(n_conv - c), 1, "conv");
		chk(eoc_n, 1'b1, "eoc high");
		chk(dout_oe, 1'b0, "oe off");
		frame(8'h00, 16);
		chk(rx, 16'h03F1, "word 2");
		chk(16'(n_conv - c), 1, "no conv");
		$display("test read done");
	endtask
	task automatic t_setup();
		int c;
		frame(8'hFF, 3);
		frame(8'h48, 8);
		chk(conversion_start_n_is_start, 1'b1, "start role");
		chk(ref_neg_is_ref, 1'b1, "ref role");
		frame(8'h58, 8);
		chk(conversion_start_n_is_start, 1'b1, "single role");
		c = n_conv;
		push(12'h123);
		chk(eoc_n, 1'b0, "eoc pushed");
		conversion_start_n = 1'b0;
		cyc(4);
		conversion_start_n = 1'b1;
		cyc(6);
		chk(16'(n_conv - c), 1, "pin conv");
		chk(eoc_n, 1'b1, "eoc start");
		frame(8'h64, 8);
		chk(conversion_start_n_is_start, 1'b0, "analog role");
		chk(ref_neg_is_ref, 1'b0, "analog ref");
		$display("test setup done");
	endtask
	task automatic t_ext();
		int c;
		frame(8'h70, 8);
		push(12'h456);
		cyc(2);
		chk(eoc_n, 1'b1, "eoc ext");
		c = n_conv;
		frame(8'h80, 16);
		chk(rx, 16'h0456, "ext word");
		chk(16'(n_conv - c), 1, "ext conv");
		frame(8'h60, 8);
		$display("test ext done");
	endtask
	task automatic t_fifo();
		for (int i = 0; i < 4; i++) push(12'h200 + 12'(i));
		cyc(1);
		chk(result_ready, 1'b0, "full");
		for (int i = 0; i < 4; i++) begin
			frame(8'h00, 16);
			chk(rx, 16'h0200 + 16'(i), "drain");
		end
		chk(result_ready, 1'b1, "empty");
		$display("test fifo done");
	endtask
	task automatic t_ignore();
		int c;
		int o;
		c = n_conv;
		o = n_oe;
		M.xfer(1'b0, 8'hFF, 8, rx);
		cyc(6);
		chk(16'(n_conv - c), 0, "quiet conv");
		chk(16'(n_oe - o), 0, "quiet oe");
		$display("test ignore done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic t_reset();
		cyc(6);
		rst_b = 1'b1;
		cyc(4);
		chk({dout_oe, eoc_n, result_ready, conversion_start_n_is_start, ref_neg_is_ref}, 5'h0C, "reset");
		$display("test reset done");
	endtask
	initial begin
		t_reset();
		t_read();
		t_setup();
		t_ext();
		t_fifo();
		t_ignore();
		report_and_stop();
	end
	// The run needs about 75 us; the limit leaves a wide margin.
	initial begin
		#2000000;
		n_mismatch++;
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
